// ---- rtl/eis_pkg.sv ----
// Shared constants and types for the two-wire EEPROM slave front end.
// Assumes a 100 ns system clock and a bus clock that comes from the master.
package eis_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int GLITCH_WIDTH_NS = 50;
    localparam int POWERUP_READY_DELAY_MS = 1;
    localparam int INTERNAL_WRITE_DURATION_MS = 5;
    localparam int NS_PER_MS = 1000000;
    // Pulses up to this many whole cycles are suppressed (least time, rounded up)
    localparam int GLITCH_FILTER_CYCLES = (GLITCH_WIDTH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // Longest times, rounded down
    localparam int POWERUP_READY_CYCLES = POWERUP_READY_DELAY_MS * NS_PER_MS / SYS_CLK_PERIOD_NS;
    localparam int INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_DURATION_MS * NS_PER_MS / SYS_CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Address byte layout and framing
    // ----------------------------------------------------------------
    localparam int ADDR_TYPE_MSB = 7;
    localparam int ADDR_TYPE_LSB = 4;
    localparam int ADDR_SEL_MSB = 3;
    localparam int ADDR_SEL_LSB = 1;
    localparam int ADDR_DIR_BIT = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] MEM_ADDR_BYTES = 2'h2;
    // Arbitrary device-type code, not tied to any real part
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_SEND_ACK = 3'h3,
        ST_RX       = 3'h2,
        ST_TX       = 3'h6,
        ST_GET_ACK  = 3'h7,
        ST_HOLD     = 3'h5
    } eis_state_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } eis_bus_ev_t;

endpackage : eis_pkg

// ---- rtl/eis_glitch_filter.sv ----
// Drops input pulses that last no longer than a set number of clock cycles.
// Assumes its input is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module eis_glitch_filter #(
    parameter int STABLE_CYCLES = eis_pkg::GLITCH_FILTER_CYCLES
) (
    input wire logic clk,     // System clock
    input wire logic rst_n,   // Synchronised reset, active low
    input wire logic din,     // Synchronised level
    output logic dout         // Filtered level
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);

    logic [CW-1:0] cnt_reg;

    // Output follows only after STABLE_CYCLES+1 equal samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            dout <= 1'b1;
        end else if (din == dout) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CW'(STABLE_CYCLES)) begin
            cnt_reg <= '0;
            dout <= din;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end
endmodule : eis_glitch_filter
`default_nettype wire

// ---- rtl/eis_front_end.sv ----
// Bus front end of a serial EEPROM acting as a two-wire slave.
// Assumes reset_n is the power-on reset and scl_in is driven by the master.
`timescale 1ns/1ps
`default_nettype none
module eis_front_end #(
    parameter int POWERUP_CYCLES = eis_pkg::POWERUP_READY_CYCLES,
    parameter int WRITE_CYCLES = eis_pkg::INTERNAL_WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE = eis_pkg::DEV_TYPE_DEFAULT  // Arbitrary value
) (
    input wire logic sys_clk,           // System clock, 10 MHz
    input wire logic reset_n,           // Power-on reset, active low, async
    input wire logic scl_in,            // Bus clock from the master
    input wire logic sda_in,            // Data line level
    output logic sda_out,               // Data line drive value, always low
    output logic sda_oe,                // Data line pull-down enable
    input wire logic addr_select_bit0,  // Address select pin 0
    input wire logic addr_select_bit1,  // Address select pin 1
    input wire logic addr_select_bit2,  // Address select pin 2
    input wire logic wp_in,             // Write protect pin
    input wire logic [7:0] tx_byte,     // Next byte to send in read mode
    output logic tx_take,               // Pulse: tx_byte loaded
    output logic [7:0] rx_byte,         // Last accepted received byte
    output logic rx_valid,              // Pulse: rx_byte updated
    output logic rx_is_data,            // rx_byte is a data byte, not address
    output logic write_start,           // Pulse: internal write launched
    output logic write_busy,            // Internal write cycle running
    output logic dev_ready              // Power-up delay elapsed
);
    localparam int PW = $clog2(POWERUP_CYCLES + 1);
    localparam int TW = $clog2(WRITE_CYCLES + 1);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Link domain: data capture on the bus clock
    // ----------------------------------------------------------------
    logic link_bit_reg;

    always_ff @(posedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            link_bit_reg <= 1'b1;
        end else begin
            link_bit_reg <= sda_in;
        end
    end

    // ----------------------------------------------------------------
    // Pin and crossing synchronisers
    // ----------------------------------------------------------------
    // Order: link bit, wp, sel2, sel1, sel0, sda, scl
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 7'h43;
            pin_sync_reg <= 7'h43;
        end else begin
            pin_meta_reg <= {link_bit_reg, wp_in, addr_select_bit2, addr_select_bit1, addr_select_bit0, sda_in, scl_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic bit_in;
    logic wp_level;
    logic [2:0] sel_pins;

    assign bit_in = pin_sync_reg[6];
    assign wp_level = pin_sync_reg[5];
    assign sel_pins = pin_sync_reg[4:2];

    // ----------------------------------------------------------------
    // Glitch filters and bus events
    // ----------------------------------------------------------------
    logic scl_f;
    logic sda_f;
    logic scl_prev_reg;
    logic sda_prev_reg;
    eis_pkg::eis_bus_ev_t ev;

    eis_glitch_filter #(
        .STABLE_CYCLES(eis_pkg::GLITCH_FILTER_CYCLES)
    ) u_scl_filter (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din(pin_sync_reg[0]),
        .dout(scl_f)
    );

    eis_glitch_filter #(
        .STABLE_CYCLES(eis_pkg::GLITCH_FILTER_CYCLES)
    ) u_sda_filter (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din(pin_sync_reg[1]),
        .dout(sda_f)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_f;
            sda_prev_reg <= sda_f;
        end
    end

    always_comb begin
        ev.scl_rise = scl_f & ~scl_prev_reg;
        ev.scl_fall = ~scl_f & scl_prev_reg;
        ev.start = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
        ev.stop = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;
    end

    // ----------------------------------------------------------------
    // Power-up delay
    // ----------------------------------------------------------------
    logic [PW-1:0] pu_cnt_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_reg <= '0;
            dev_ready <= 1'b0;
        end else if (pu_cnt_reg == PW'(POWERUP_CYCLES)) begin
            dev_ready <= 1'b1;
        end else begin
            pu_cnt_reg <= pu_cnt_reg + PW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Internal write cycle timer
    // ----------------------------------------------------------------
    logic [TW-1:0] wr_cnt_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_cnt_reg <= '0;
            write_busy <= 1'b0;
        end else if (write_start) begin
            wr_cnt_reg <= TW'(WRITE_CYCLES);
            write_busy <= 1'b1;
        end else if (wr_cnt_reg != '0) begin
            wr_cnt_reg <= wr_cnt_reg - TW'(1);
            write_busy <= (wr_cnt_reg != TW'(1));
        end
    end

    // ----------------------------------------------------------------
    // Protocol state machine
    // ----------------------------------------------------------------
    eis_pkg::eis_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_shift_reg;
    logic [1:0] byte_idx_reg;
    logic addr_hit_reg;
    logic read_reg;
    logic wr_cmd_reg;
    logic data_seen_reg;
    logic wp_lock_reg;
    logic ack_ok_reg;
    logic [7:0] shift_next;
    logic addr_match;

    assign shift_next = {shift_reg[6:0], bit_in};
    assign addr_match = (shift_next[eis_pkg::ADDR_TYPE_MSB:eis_pkg::ADDR_TYPE_LSB] == DEV_TYPE)
        && (shift_next[eis_pkg::ADDR_SEL_MSB:eis_pkg::ADDR_SEL_LSB] == sel_pins)
        && !write_busy;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= eis_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_shift_reg <= 8'hff;
            byte_idx_reg <= 2'h0;
            addr_hit_reg <= 1'b0;
            read_reg <= 1'b0;
            wr_cmd_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            wp_lock_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            sda_oe <= 1'b0;
            tx_take <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            rx_is_data <= 1'b0;
            write_start <= 1'b0;
        end else begin
            tx_take <= 1'b0;
            rx_valid <= 1'b0;
            write_start <= 1'b0;
            if (!dev_ready) begin
                state_reg <= eis_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (ev.stop) begin
                write_start <= wr_cmd_reg && data_seen_reg && !write_busy;
                wr_cmd_reg <= 1'b0;
                data_seen_reg <= 1'b0;
                state_reg <= eis_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (ev.start) begin
                // Repeated START drops a write with no data byte (dummy write for address set)
                write_start <= 1'b0;
                wr_cmd_reg <= wr_cmd_reg && data_seen_reg;
                state_reg <= eis_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else begin
                case (state_reg)
                    eis_pkg::ST_ADDR: begin
                        if (ev.scl_rise) begin
                            shift_reg <= shift_next;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == eis_pkg::BITS_PER_BYTE - 4'h1) begin
                                addr_hit_reg <= addr_match;
                                read_reg <= shift_next[eis_pkg::ADDR_DIR_BIT];
                            end
                        end else if (ev.scl_fall && bit_cnt_reg == eis_pkg::BITS_PER_BYTE) begin
                            bit_cnt_reg <= 4'h0;
                            byte_idx_reg <= 2'h0;
                            if (addr_hit_reg) begin
                                state_reg <= eis_pkg::ST_SEND_ACK;
                                sda_oe <= 1'b1;
                                if (!read_reg) begin
                                    wr_cmd_reg <= 1'b1;
                                    data_seen_reg <= 1'b0;
                                end
                            end else begin
                                state_reg <= eis_pkg::ST_HOLD;
                            end
                        end
                    end
                    eis_pkg::ST_SEND_ACK: begin
                        if (ev.scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (read_reg) begin
                                state_reg <= eis_pkg::ST_TX;
                                tx_shift_reg <= tx_byte;
                                tx_take <= 1'b1;
                                sda_oe <= ~tx_byte[7];
                            end else begin
                                state_reg <= eis_pkg::ST_RX;
                                sda_oe <= 1'b0;
                                if (byte_idx_reg == eis_pkg::MEM_ADDR_BYTES) begin
                                    wp_lock_reg <= wp_level;
                                end
                            end
                        end
                    end
                    eis_pkg::ST_RX: begin
                        if (ev.scl_rise) begin
                            shift_reg <= shift_next;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (ev.scl_fall && bit_cnt_reg == eis_pkg::BITS_PER_BYTE) begin
                            bit_cnt_reg <= 4'h0;
                            if (byte_idx_reg == eis_pkg::MEM_ADDR_BYTES && wp_lock_reg) begin
                                state_reg <= eis_pkg::ST_HOLD;
                                wr_cmd_reg <= 1'b0;
                            end else begin
                                state_reg <= eis_pkg::ST_SEND_ACK;
                                sda_oe <= 1'b1;
                                rx_byte <= shift_reg;
                                rx_valid <= 1'b1;
                                rx_is_data <= (byte_idx_reg == eis_pkg::MEM_ADDR_BYTES);
                                if (byte_idx_reg == eis_pkg::MEM_ADDR_BYTES) begin
                                    data_seen_reg <= 1'b1;
                                end else begin
                                    byte_idx_reg <= byte_idx_reg + 2'h1;
                                end
                            end
                        end
                    end
                    eis_pkg::ST_TX: begin
                        if (ev.scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (ev.scl_fall) begin
                            tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                            if (bit_cnt_reg == eis_pkg::BITS_PER_BYTE) begin
                                bit_cnt_reg <= 4'h0;
                                state_reg <= eis_pkg::ST_GET_ACK;
                                sda_oe <= 1'b0;
                            end else begin
                                sda_oe <= ~tx_shift_reg[6];
                            end
                        end
                    end
                    eis_pkg::ST_GET_ACK: begin
                        if (ev.scl_rise) begin
                            ack_ok_reg <= ~bit_in;
                        end else if (ev.scl_fall) begin
                            if (ack_ok_reg) begin
                                state_reg <= eis_pkg::ST_TX;
                                tx_shift_reg <= tx_byte;
                                tx_take <= 1'b1;
                                sda_oe <= ~tx_byte[7];
                            end else begin
                                state_reg <= eis_pkg::ST_HOLD;
                            end
                        end
                    end
                    eis_pkg::ST_HOLD: begin
                        sda_oe <= 1'b0;
                    end
                    eis_pkg::ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state_reg <= eis_pkg::ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open drain: the device never drives a high level
    assign sda_out = 1'b0;

endmodule : eis_front_end
`default_nettype wire

// ---- sim/eis_fe_monitor.sv ----
// Checker for the two-wire slave front end, bound to its top ports.
// Assumes one sys_clk domain and the active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module eis_fe_monitor #(
    parameter int POWERUP_CYCLES = 20,
    parameter int WRITE_CYCLES = 400
) (
    input wire logic sys_clk,     // System clock
    input wire logic reset_n,     // Reset, active low
    input wire logic scl_in,      // Bus clock
    input wire logic sda_out,     // Drive value
    input wire logic sda_oe,      // Pull-down enable
    input wire logic rx_valid,    // Byte strobe
    input wire logic write_start, // Write launch
    input wire logic write_busy,  // Write running
    input wire logic dev_ready    // Ready flag
);
    logic [15:0] busy_cnt_reg;
    logic [15:0] wait_cnt_reg;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) busy_cnt_reg <= 16'h0;
        else if (write_busy) busy_cnt_reg <= busy_cnt_reg + 16'h1;
        else busy_cnt_reg <= 16'h0;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) wait_cnt_reg <= 16'h0;
        else if (!dev_ready) wait_cnt_reg <= wait_cnt_reg + 16'h1;
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    open_drain_a: assert property (
        sda_oe |-> sda_out == 1'b0) else $error("data line driven high");
    ready_bound_a: assert property (
        wait_cnt_reg <= 16'(POWERUP_CYCLES + 4)) else $error("ready too late");
    ready_kept_a: assert property (
        dev_ready |=> dev_ready) else $error("ready dropped");
    drive_scl_low_a: assert property (
        $changed(sda_oe) |-> !scl_in) else $error("data drive changed with clock high");
    busy_follows_a: assert property (
        write_start |-> ##[0:1] write_busy) else $error("write did not start");
    busy_length_a: assert property (
        $fell(write_busy) |-> busy_cnt_reg == 16'(WRITE_CYCLES)) else $error("write length wrong");
    no_ack_busy_a: assert property (
        write_busy |-> !$rose(sda_oe)) else $error("answered while busy");
    launch_idle_a: assert property (
        write_start |-> !$past(write_busy) ##1 !write_start) else $error("bad write launch");
    quiet_unready_a: assert property (
        !dev_ready |-> !sda_oe && !rx_valid) else $error("active before ready");
    byte_pulse_a: assert property (
        rx_valid |=> !rx_valid [*3]) else $error("byte strobe too long");
endmodule : eis_fe_monitor
`default_nettype wire

// ---- sim/eis_fe_bus_master.sv ----
// Behavioural two-wire bus master driving clock, START and STOP.
// Assumes a pull-up on the data line, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module eis_fe_bus_master #(
    parameter int H = 996
) (
    output logic scl,     // Bus clock to the slave
    output logic pull,    // High while master pulls data low
    input wire logic sda  // Resolved data line
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic bit_x(input logic b, output logic s);
        #(H/2) pull = !b;
        #(H/2) scl = 1'b1;
        #(H/2) s = sda;
        #(H/2) scl = 1'b0;
    endtask : bit_x

    task automatic start();
        pull = 1'b0;
        #(H/2) scl = 1'b1;
        #H pull = 1'b1;
        #H scl = 1'b0;
    endtask : start

    task automatic stop();
        #(H/2) pull = 1'b1;
        #(H/2) scl = 1'b1;
        #H pull = 1'b0;
        #(2*H);
    endtask : stop

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
        bit_x(!ack, s);
    endtask : rd_byte
endmodule : eis_fe_bus_master
`default_nettype wire

// ---- sim/eis_front_end_tb.sv ----
// Self-checking bench for the two-wire slave front end.
// Assumes the bus master model drives the bus and the bench resolves it.
`timescale 1ns/1ps
`default_nettype none
module eis_front_end_tb;
    localparam logic [3:0] DT = eis_pkg::DEV_TYPE_DEFAULT;
    logic sys_clk, reset_n, scl, m_pull, sda_line, sda_out, sda_oe, wp, tx_take;
    logic rx_valid, rx_is_data, write_start, write_busy, dev_ready;
    logic [2:0] sel;
    logic [7:0] tx_byte, rx_byte;
    logic [8:0] last_rx = 9'h0;
    int error_cnt, checked;
    int ws_cnt = 0;
    int tk_cnt = 0;

    // Read data source: a new byte after every load
    assign tx_byte = tk_cnt[0] ? 8'h3c : 8'ha5;

    // Pull-up on the data line, pulled low by either party
    assign sda_line = (m_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    eis_front_end #(.POWERUP_CYCLES(20), .WRITE_CYCLES(400)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .wp_in(wp),
        .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_is_data(rx_is_data), .write_start(write_start), .write_busy(write_busy),
        .dev_ready(dev_ready));
    eis_fe_bus_master u_mst (.scl(scl), .pull(m_pull), .sda(sda_line));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) last_rx <= {rx_is_data, rx_byte};
        if (write_start === 1'b1) ws_cnt <= ws_cnt + 1;
        if (tx_take === 1'b1) tk_cnt <= tk_cnt + 1;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] sla(input logic [3:0] t, input logic [2:0] s, input logic rd);
        return {t, s, rd};
    endfunction : sla

    task automatic t_select();
        logic a;
        for (int i = 0; i < 9; i++) begin
            u_mst.start();
            u_mst.wr_byte(sla(i < 8 ? DT : ~DT, i < 8 ? 3'(i) : sel, 1'b0), a);
            check({8'h0, a}, {8'h0, i < 8 && 3'(i) == sel});
            u_mst.stop();
        end
    endtask : t_select

    task automatic t_glitch();
        logic a;
        u_mst.start();
        #300 u_mst.scl = 1'b1;
        #40 u_mst.scl = 1'b0;
        u_mst.wr_byte(sla(DT, sel, 1'b0), a);
        check({8'h0, a}, 9'h1);
        u_mst.stop();
    endtask : t_glitch

    task automatic t_write();
        logic a;
        int n;
        n = ws_cnt;
        u_mst.start();
        u_mst.wr_byte(sla(DT, sel, 1'b0), a);
        check({8'h0, a}, 9'h1);
        u_mst.wr_byte(8'h12, a);
        u_mst.wr_byte(8'h34, a);
        check(last_rx, 9'h034);
        u_mst.wr_byte(8'hc3, a);
        check({8'h0, a}, 9'h1);
        check(last_rx, 9'h1c3);
        u_mst.stop();
        check(9'(ws_cnt - n), 9'h1);
        check({8'h0, write_busy}, 9'h1);
        u_mst.start();
        u_mst.wr_byte(sla(DT, sel, 1'b1), a);
        check({8'h0, a}, 9'h0);
        u_mst.stop();
        for (n = 0; n < 1000 && write_busy !== 1'b0; n++) @(posedge sys_clk);
        check({8'h0, write_busy}, 9'h0);
    endtask : t_write

    task automatic t_wp();
        logic a;
        int n;
        n = ws_cnt;
        @(posedge sys_clk);
        #2 wp = 1'b1;
        u_mst.start();
        u_mst.wr_byte(sla(DT, sel, 1'b0), a);
        u_mst.wr_byte(8'h00, a);
        u_mst.wr_byte(8'h01, a);
        check({8'h0, a}, 9'h1);
        u_mst.wr_byte(8'h5a, a);
        check({8'h0, a}, 9'h0);
        u_mst.stop();
        check(9'(ws_cnt - n), 9'h0);
        @(posedge sys_clk);
        #2 wp = 1'b0;
    endtask : t_wp

    task automatic t_read();
        logic a;
        logic [7:0] b;
        int n;
        n = tk_cnt;
        u_mst.start();
        u_mst.wr_byte(sla(DT, sel, 1'b1), a);
        check({8'h0, a}, 9'h1);
        u_mst.rd_byte(b, 1'b1);
        check({1'b0, b}, 9'h0a5);
        u_mst.rd_byte(b, 1'b0);
        check({1'b0, b}, 9'h03c);
        u_mst.stop();
        check(9'(tk_cnt - n), 9'h2);
    endtask : t_read

    initial begin
        reset_n = 1'b0;
        sel = 3'h5;
        wp = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (3) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        for (int i = 0; i < 100 && dev_ready !== 1'b1; i++) @(posedge sys_clk);
        check({8'h0, dev_ready}, 9'h1);
        t_select();
        t_glitch();
        t_write();
        t_wp();
        t_read();
        give_verdict();
    end

    initial begin
        #5000000;
        error_cnt++;
        give_verdict();
    end
endmodule : eis_front_end_tb

bind eis_front_end eis_fe_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .rx_valid(rx_valid), .write_start(write_start), .write_busy(write_busy), .dev_ready(dev_ready));
`default_nettype wire
